// File: pkg/mcqs_defines.svh
// Constants of the multilink class queue scheduler.
// Assumes one 100 MHz clock; included by the package and the design.
// Function
// RULE1: Four fragment queues per bundle; all service points of a class share one.
// RULE2: Every fragment of one packet enters the class queue chosen at its first.
// RULE3: Out-of-profile packet dropped once queue fill reaches the out-of-profile threshold.
// RULE4: In-profile packet dropped only once queue fill reaches the maximum threshold.
// RULE5: Out-of-profile threshold is half the maximum, not programmable.
// RULE6: Reset thresholds in ms: 10/5, 50/25, 150/75, 750/375 for classes 0-3.
// RULE7: Minimum rate applies to class one only, as percent of bundle rate.
// RULE8: Defaults: class one minimum 90, class one weight 1, weights 89 and 10.
// RULE9: Class one weight fixed at one; classes two, three share by integer weights.
// RULE10: Rates and thresholds follow the current bundle rate when links change.
// RULE11: Reassembly timers default to 10, 10, 100, 100 ms.
// RULE12: Profile reassignment waits for shutdown; parameter edits apply at once.
// RULE13: End-to-end fragments of class 0/1 go high priority, 2/3 low priority.
// RULE14: High queue peak is sum of peak rates; low weight is sum of committed rates.
// RULE15: Up to 128 ingress and 128 egress profiles, numbered 1 to 65535; code accepts id 0 and resets slots 1-127 to id 0.
// RULE16: Per-class parameters indexed by class zero to three.
// RULE17: Reassembly timer programmable 1 to 1000 ms.
// RULE18: Class queue maximum programmable 1 to 1000 ms.
// RULE19: Minimum rate and weights accept 1 to 100.
// RULE20: Eight forwarding classes map many-to-one onto classes 0-3.
// RULE21: Class zero strict priority, then minimum rate, then weighted round robin.
`ifndef MCQS_DEFINES_SVH
`define MCQS_DEFINES_SVH
`define MCQS_NPROF      128
`define MCQS_OFF_CTRL   8'h00
`define MCQS_OFF_SEL    8'h04
`define MCQS_OFF_EGID   8'h08
`define MCQS_OFF_MIR    8'h0C
`define MCQS_OFF_W2     8'h10
`define MCQS_OFF_W3     8'h14
`define MCQS_OFF_FCMAP  8'h18
`define MCQS_OFF_INID   8'h1C
`define MCQS_OFF_QMAX   8'h20
`define MCQS_OFF_TMO    8'h30
`define MCQS_OFF_BIND   8'h40
`define MCQS_OFF_ACT    8'h44
`define MCQS_OFF_FILL   8'h50
`define MCQS_MS_MAX     10'h3E8
`define MCQS_PCT_MAX    7'h64
`define MCQS_DEF_QMAX   {10'h2EE, 10'h096, 10'h032, 10'h00A}
`define MCQS_DEF_TMO    {10'h064, 10'h064, 10'h00A, 10'h00A}
`define MCQS_DEF_MIR    7'h5A
`define MCQS_DEF_W1     8'h01
`define MCQS_DEF_W2     7'h59
`define MCQS_DEF_W3     7'h0A
`define MCQS_DEF_FCMAP  16'h16AB
`define MCQS_DEF_ID     16'h0001
`define MCQS_WIN_LAST   7'h63
`endif

// File: pkg/mcqs_pkg.sv
// Types of the multilink class queue scheduler.
// Assumes the defines header sits beside it.
`include "mcqs_defines.svh"
package mcqs_pkg;
  typedef logic [`MCQS_NPROF-1:0][3:0][9:0] mcqs_ms_arr_t;
  typedef logic [`MCQS_NPROF-1:0][6:0]      mcqs_pct_arr_t;
  typedef struct packed {
    logic [`MCQS_NPROF-1:0][15:0] eg_id;
    mcqs_ms_arr_t                 eg_qmax;
    mcqs_pct_arr_t                eg_mir;
    mcqs_pct_arr_t                eg_w2;
    mcqs_pct_arr_t                eg_w3;
    logic [`MCQS_NPROF-1:0][15:0] eg_fcmap;
    logic [`MCQS_NPROF-1:0][15:0] in_id;
    mcqs_ms_arr_t                 in_tmo;
    logic [6:0]                   sel;
    logic [6:0]                   pend_eg;
    logic [6:0]                   pend_in;
    logic [6:0]                   act_eg;
    logic [6:0]                   act_in;
    logic                         e2e_en;
    logic [1:0]                   down_sync;
    logic [3:0][25:0]             fill;
    logic [1:0]                   pkt_cls;
    logic                         pkt_drop;
    logic [6:0]                   win_cnt;
    logic [6:0]                   c1_cnt;
    logic [3:1][7:0]              cred;
    logic                         enq_vld;
    logic                         enq_drop;
    logic [1:0]                   enq_cls;
    logic                         grant;
    logic [1:0]                   grant_cls;
    logic                         e2e_hi;
    logic [26:0]                  hp_pir;
    logic [26:0]                  lp_wgt;
    logic [31:0]                  rdata;
  } mcqs_state_t;
endpackage

// File: hdl/mcqs_top.sv
// Class queue admission, scheduling and profile store of a four-class bundle.
// Assumes fragment storage and member-link transmit live outside; one clock.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "mcqs_defines.svh"
module mcqs_top
  import mcqs_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_b,
  // Register port
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  // Bundle state
  input  wire logic                    i_bundle_down,
  input  wire logic [15:0]             i_rate_bpms,
  // Fragment admission
  input  wire logic                    i_frag_valid,
  input  wire logic                    i_frag_first,
  input  wire logic [2:0]              i_frag_fc,
  input  wire logic                    i_frag_oop,
  input  wire logic [15:0]             i_frag_len,
  output logic                         o_enq_valid,
  output logic                         o_enq_drop,
  output logic      [1:0]              o_enq_class,
  // Dequeue
  input  wire logic                    i_tx_req,
  input  wire logic                    i_deq_valid,
  input  wire logic [1:0]              i_deq_class,
  input  wire logic [15:0]             i_deq_len,
  output logic                         o_tx_grant,
  output logic      [1:0]              o_tx_class,
  // Ingress profile
  output logic      [3:0][9:0]         o_reasm_tmo,
  // End-to-end fragmentation
  input  wire logic [1:0]              i_e2e_class,
  input  wire logic [7:0][23:0]        i_fc_pir,
  input  wire logic [7:0][23:0]        i_fc_cir,
  output logic                         o_e2e_hi,
  output logic      [26:0]             o_hp_pir,
  output logic      [26:0]             o_lp_weight
);

  mcqs_state_t s_r;
  mcqs_state_t s_nxt;

  logic [3:0][25:0] thr_max;
  logic [3:0][25:0] thr_oop;
  logic [3:0]       busy;
  logic [1:0]       fcls;
  logic             fdrop;
  logic [3:1][7:0]  ecred;
  logic [1:0]       pick;
  logic             any;
  logic [15:0]      fmap;
  logic [9:0]       wv;
  logic [6:0]       wp;
  logic [3:0]       wc;
  logic [6:0]       a_eg;

  assign a_eg = s_r.act_eg;
  assign fmap = s_r.eg_fcmap[a_eg];
  assign wv   = i_wdata[9:0];
  assign wp   = i_wdata[6:0];
  assign wc   = i_addr[3:0];

  // Thresholds in bytes at the present bundle rate
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // Operands widened first so the product cannot wrap
      thr_max[c] = 26'(s_r.eg_qmax[a_eg][c]) * 26'(i_rate_bpms); // RULE10 RULE4
      thr_oop[c] = ((26'(s_r.eg_qmax[a_eg][c]) + 26'h0000001) >> 1) * // RULE5 RULE3
                   26'(i_rate_bpms);
      busy[c]    = s_r.fill[c] != 26'h0000000;
    end
  end

  // Class and admission of the arriving fragment
  always_comb begin
    fcls  = s_r.pkt_cls;
    fdrop = s_r.pkt_drop;
    if (i_frag_first) begin
      fcls  = fmap[2*i_frag_fc +: 2]; // RULE20 RULE1
      fdrop = (s_r.fill[fcls] >= thr_max[fcls]) || // RULE4
              (i_frag_oop && s_r.fill[fcls] >= thr_oop[fcls]); // RULE3
    end
  end

  // Scheduler choice
  always_comb begin
    ecred = s_r.cred;
    // Credits reload only once no waiting class holds any
    if (!((busy[1] && s_r.cred[1] != 8'h00) || (busy[2] && s_r.cred[2] != 8'h00) ||
          (busy[3] && s_r.cred[3] != 8'h00)))
      ecred = {1'b0, s_r.eg_w3[a_eg], 1'b0, s_r.eg_w2[a_eg], `MCQS_DEF_W1}; // RULE9
    any  = busy != 4'h0;
    pick = 2'h0;
    if (busy[0])
      pick = 2'h0; // RULE21
    else if (busy[1] && s_r.c1_cnt < s_r.eg_mir[a_eg])
      pick = 2'h1; // RULE7
    else if (busy[1] && ecred[1] != 8'h00)
      pick = 2'h1; // RULE9
    else if (busy[2] && ecred[2] != 8'h00)
      pick = 2'h2; // RULE9
    else if (busy[3])
      pick = 2'h3;
    else if (busy[2])
      pick = 2'h2;
    else
      pick = 2'h1;
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.enq_vld  = 1'b0;
    s_nxt.grant    = 1'b0;
    s_nxt.down_sync = {s_r.down_sync[0], i_bundle_down};
    if (!i_rst_b) begin
      for (int p = 0; p < `MCQS_NPROF; p++) begin
        s_nxt.eg_id[p]    = 16'h0000;
        s_nxt.in_id[p]    = 16'h0000;
        s_nxt.eg_qmax[p]  = `MCQS_DEF_QMAX; // RULE6
        s_nxt.eg_mir[p]   = `MCQS_DEF_MIR; // RULE8
        s_nxt.eg_w2[p]    = `MCQS_DEF_W2; // RULE8
        s_nxt.eg_w3[p]    = `MCQS_DEF_W3; // RULE8
        s_nxt.eg_fcmap[p] = `MCQS_DEF_FCMAP;
        s_nxt.in_tmo[p]   = `MCQS_DEF_TMO; // RULE11
      end
      s_nxt.eg_id[0]   = `MCQS_DEF_ID;
      s_nxt.in_id[0]   = `MCQS_DEF_ID;
      s_nxt.sel        = 7'h00;
      s_nxt.pend_eg    = 7'h00;
      s_nxt.pend_in    = 7'h00;
      s_nxt.act_eg     = 7'h00;
      s_nxt.act_in     = 7'h00;
      s_nxt.e2e_en     = 1'b0;
      s_nxt.down_sync  = 2'h0;
      s_nxt.fill       = '0;
      s_nxt.pkt_cls    = 2'h0;
      s_nxt.pkt_drop   = 1'b0;
      s_nxt.win_cnt    = 7'h00;
      s_nxt.c1_cnt     = 7'h00;
      s_nxt.cred       = '0;
      s_nxt.enq_drop   = 1'b0;
      s_nxt.enq_cls    = 2'h0;
      s_nxt.grant_cls  = 2'h0;
      s_nxt.e2e_hi     = 1'b0;
      s_nxt.hp_pir     = 27'h0000000;
      s_nxt.lp_wgt     = 27'h0000000;
      s_nxt.rdata      = 32'h00000000;
    end else begin
      // Register writes; profile fields go into the selected slot, control, select and bind do not
      if (i_wr) begin
        unique case (i_addr)
          `MCQS_OFF_CTRL:  s_nxt.e2e_en = i_wdata[0];
          `MCQS_OFF_SEL:   s_nxt.sel = i_wdata[6:0]; // RULE15
          `MCQS_OFF_EGID:  s_nxt.eg_id[s_r.sel] = i_wdata[15:0]; // RULE15
          `MCQS_OFF_INID:  s_nxt.in_id[s_r.sel] = i_wdata[15:0]; // RULE15
          `MCQS_OFF_MIR:   if (wp != 7'h00 && wp <= `MCQS_PCT_MAX && i_wdata[31:7] == 25'h0)
                             s_nxt.eg_mir[s_r.sel] = wp; // RULE19
          `MCQS_OFF_W2:    if (wp != 7'h00 && wp <= `MCQS_PCT_MAX && i_wdata[31:7] == 25'h0)
                             s_nxt.eg_w2[s_r.sel] = wp; // RULE19
          `MCQS_OFF_W3:    if (wp != 7'h00 && wp <= `MCQS_PCT_MAX && i_wdata[31:7] == 25'h0)
                             s_nxt.eg_w3[s_r.sel] = wp; // RULE19
          `MCQS_OFF_FCMAP: s_nxt.eg_fcmap[s_r.sel] = i_wdata[15:0]; // RULE20
          `MCQS_OFF_BIND: begin
            s_nxt.pend_eg = i_wdata[6:0];
            s_nxt.pend_in = i_wdata[14:8];
          end
          default: begin
            // Class from address bits 3:2; word-aligned offsets only
            if (wv != 10'h000 && wv <= `MCQS_MS_MAX && i_wdata[31:10] == 22'h0 &&
                wc[1:0] == 2'h0) begin
              if (i_addr[7:4] == 4'(`MCQS_OFF_QMAX >> 4))
                s_nxt.eg_qmax[s_r.sel][wc[3:2]] = wv; // RULE18 RULE16
              if (i_addr[7:4] == 4'(`MCQS_OFF_TMO >> 4))
                s_nxt.in_tmo[s_r.sel][wc[3:2]] = wv; // RULE17 RULE16
            end
          end
        endcase
      end
      // Bound slots change only while the bundle is down
      if (s_r.down_sync[1]) begin
        s_nxt.act_eg = s_r.pend_eg; // RULE12
        s_nxt.act_in = s_r.pend_in; // RULE12
      end
      // Register reads, answered in the next cycle
      if (i_rd) begin
        s_nxt.rdata = 32'h00000000;
        unique case (i_addr)
          `MCQS_OFF_CTRL:  s_nxt.rdata[0] = s_r.e2e_en;
          `MCQS_OFF_SEL:   s_nxt.rdata[6:0] = s_r.sel;
          `MCQS_OFF_EGID:  s_nxt.rdata[15:0] = s_r.eg_id[s_r.sel];
          `MCQS_OFF_INID:  s_nxt.rdata[15:0] = s_r.in_id[s_r.sel];
          `MCQS_OFF_MIR:   s_nxt.rdata[6:0] = s_r.eg_mir[s_r.sel];
          `MCQS_OFF_W2:    s_nxt.rdata[6:0] = s_r.eg_w2[s_r.sel];
          `MCQS_OFF_W3:    s_nxt.rdata[6:0] = s_r.eg_w3[s_r.sel];
          `MCQS_OFF_FCMAP: s_nxt.rdata[15:0] = s_r.eg_fcmap[s_r.sel];
          `MCQS_OFF_BIND:  s_nxt.rdata[14:0] = {s_r.pend_in, 1'b0, s_r.pend_eg};
          `MCQS_OFF_ACT:   s_nxt.rdata[14:0] = {s_r.act_in, 1'b0, s_r.act_eg};
          default: begin
            if (wc[1:0] == 2'h0) begin
              if (i_addr[7:4] == 4'(`MCQS_OFF_QMAX >> 4))
                s_nxt.rdata[9:0] = s_r.eg_qmax[s_r.sel][wc[3:2]];
              if (i_addr[7:4] == 4'(`MCQS_OFF_TMO >> 4))
                s_nxt.rdata[9:0] = s_r.in_tmo[s_r.sel][wc[3:2]];
              if (i_addr[7:4] == 4'(`MCQS_OFF_FILL >> 4))
                s_nxt.rdata[25:0] = s_r.fill[wc[3:2]];
            end
          end
        endcase
      end
      // Admission; a packet keeps the class and verdict of its first fragment
      if (i_frag_valid) begin
        s_nxt.pkt_cls  = fcls; // RULE2
        s_nxt.pkt_drop = fdrop; // RULE2
        s_nxt.enq_vld  = 1'b1;
        s_nxt.enq_cls  = fcls;
        s_nxt.enq_drop = fdrop;
      end
      // Fill accounting, debit before credit of the same class
      if (i_deq_valid)
        s_nxt.fill[i_deq_class] = (s_r.fill[i_deq_class] > 26'(i_deq_len)) ?
                                  s_r.fill[i_deq_class] - 26'(i_deq_len) : 26'h0000000;
      if (i_frag_valid && !fdrop)
        s_nxt.fill[fcls] = s_nxt.fill[fcls] + 26'(i_frag_len); // RULE1
      // Grant one class per request
      if (i_tx_req && any) begin
        s_nxt.grant     = 1'b1;
        s_nxt.grant_cls = pick; // RULE21
        if (pick != 2'h0) begin
          s_nxt.cred = ecred;
          if (ecred[pick] != 8'h00)
            s_nxt.cred[pick] = ecred[pick] - 8'h01; // RULE9
          s_nxt.win_cnt = (s_r.win_cnt == `MCQS_WIN_LAST) ? 7'h00 : s_r.win_cnt + 7'h01;
          if (s_r.win_cnt == `MCQS_WIN_LAST)
            s_nxt.c1_cnt = 7'h00;
          else if (pick == 2'h1)
            s_nxt.c1_cnt = s_r.c1_cnt + 7'h01; // RULE7
        end
      end
      // End-to-end fragmentation queue choice and rates
      s_nxt.e2e_hi = s_r.e2e_en && (i_e2e_class < 2'h2); // RULE13
      s_nxt.hp_pir = 27'h0000000;
      s_nxt.lp_wgt = 27'h0000000;
      for (int f = 0; f < 8; f++) begin
        s_nxt.hp_pir = s_nxt.hp_pir + 27'(i_fc_pir[f]); // RULE14
        s_nxt.lp_wgt = s_nxt.lp_wgt + 27'(i_fc_cir[f]); // RULE14
      end
    end
  end

  always_ff @(posedge i_clock) begin
    s_r <= s_nxt;
  end

  assign o_rdata     = s_r.rdata;
  assign o_enq_valid = s_r.enq_vld;
  assign o_enq_drop  = s_r.enq_drop;
  assign o_enq_class = s_r.enq_cls;
  assign o_tx_grant  = s_r.grant;
  assign o_tx_class  = s_r.grant_cls;
  assign o_reasm_tmo = s_r.in_tmo[s_r.act_in];
  assign o_e2e_hi    = s_r.e2e_hi;
  assign o_hp_pir    = s_r.hp_pir;
  assign o_lp_weight = s_r.lp_wgt;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // Request steps seen by the scheduler, and the held bundle-down step
  sequence s_req_c0;
    i_tx_req && busy[0];
  endsequence

  sequence s_req_c1_min;
    i_tx_req && !busy[0] && busy[1] && s_r.c1_cnt < s_r.eg_mir[a_eg];
  endsequence

  sequence s_down_held;
    s_r.down_sync[1] ##1 1'b1;
  endsequence

  // Scheduling order
  a_strict_class0: assert property (s_req_c0 |=> o_tx_grant && o_tx_class == 2'h0) // RULE21
    else $error("class zero not served first");
  a_no_grant_idle: assert property (i_tx_req && busy == 4'h0 |=> !o_tx_grant) // RULE21
    else $error("grant with all queues empty");
  a_grant_busy: assert property (i_tx_req && busy != 4'h0 |=> o_tx_grant) // RULE21
    else $error("request with a waiting queue not granted");
  a_mir_first: assert property (s_req_c1_min |=> o_tx_grant && o_tx_class == 2'h1) // RULE7
    else $error("class one not served below its minimum rate");
  a_mir_window: assert property (s_r.c1_cnt <= s_r.win_cnt) // RULE7
    else $error("class one count outside its window");
  a_c1_weight: assert property (s_r.cred[1] <= `MCQS_DEF_W1) // RULE9
    else $error("class one credit above its fixed weight");

  // Admission and queue fill
  a_oop_drop: assert property (i_frag_valid && i_frag_first && i_frag_oop && // RULE3
      s_r.fill[fcls] >= thr_oop[fcls] |=> o_enq_valid && o_enq_drop)
    else $error("out-of-profile packet admitted above threshold");
  a_inprof_keep: assert property (i_frag_valid && i_frag_first && !i_frag_oop && // RULE4
      s_r.fill[fcls] < thr_max[fcls] |=> !o_enq_drop)
    else $error("in-profile packet dropped below maximum");
  a_same_class: assert property (i_frag_valid && !i_frag_first |=> // RULE2
      o_enq_class == $past(s_r.pkt_cls))
    else $error("fragment left its packet class");
  a_same_drop: assert property (i_frag_valid && !i_frag_first |=> // RULE2
      o_enq_drop == $past(s_r.pkt_drop))
    else $error("fragment left its packet verdict");
  a_oop_half: assert property (27'(thr_oop[3]) * 27'h0000002 == 27'(thr_max[3]) + // RULE5
      (s_r.eg_qmax[a_eg][3][0] ? 27'(i_rate_bpms) : 27'h0000000))
    else $error("out-of-profile threshold not half of maximum");
  a_fill_add: assert property (i_frag_valid && !fdrop && fcls == 2'h0 && !i_deq_valid // RULE1
      |=> s_r.fill[0] == $past(s_r.fill[0]) + 26'($past(i_frag_len)))
    else $error("admitted fragment not added to its queue");
  a_fill_empty: assert property (i_deq_valid && i_deq_class == 2'h0 && !i_frag_valid && // RULE1
      s_r.fill[0] <= 26'(i_deq_len) |=> s_r.fill[0] == 26'h0000000)
    else $error("queue fill not cleared by a full debit");

  // Profile ranges and binding
  a_wgt_range: assert property (s_r.eg_w2[s_r.sel] != 7'h00 && // RULE19
      s_r.eg_w2[s_r.sel] <= `MCQS_PCT_MAX)
    else $error("weight outside range");
  a_qmax_range: assert property (s_r.eg_qmax[s_r.sel][0] != 10'h000 && // RULE18
      s_r.eg_qmax[s_r.sel][0] <= `MCQS_MS_MAX)
    else $error("queue maximum outside range");
  a_tmo_range: assert property (s_r.in_tmo[s_r.sel][0] != 10'h000 && // RULE17
      s_r.in_tmo[s_r.sel][0] <= `MCQS_MS_MAX)
    else $error("reassembly timer outside range");
  a_bind_hold: assert property (!s_r.down_sync[1] |=> // RULE12
      $stable(s_r.act_eg) && $stable(s_r.act_in))
    else $error("profile changed while bundle up");
  a_bind_take: assert property (s_down_held |-> s_r.act_eg == $past(s_r.pend_eg)) // RULE12
    else $error("profile not taken during shutdown");

  // End-to-end queue choice
  a_e2e_map: assert property (o_e2e_hi |-> $past(s_r.e2e_en) && $past(i_e2e_class) < 2'h2) // RULE13
    else $error("wrong end-to-end queue");
  a_e2e_low: assert property (!s_r.e2e_en || i_e2e_class >= 2'h2 |=> !o_e2e_hi) // RULE13
    else $error("low class sent to the high queue");

endmodule // mcqs_top

// File: test/mcqs_link_model.sv
// Member-link side model: asks for the next class and removes what it sent.
// Assumes the scheduler grants one cycle after a request; i_gap slows the dequeue.
`timescale 1ns/100ps
module mcqs_link_model (
  // Clock
  input  wire logic        i_clock,
  // Control from the bench
  input  wire logic        i_go,
  input  wire logic [1:0]  i_gap,
  input  wire logic [15:0] i_len,
  // Scheduler answer
  input  wire logic        i_grant,
  input  wire logic [1:0]  i_grant_class,
  // Requests to the scheduler
  output logic             o_tx_req,
  output logic             o_deq_valid,
  output logic      [1:0]  o_deq_class,
  output logic      [15:0] o_deq_len
);
  logic [1:0] cls;
  initial begin
    o_tx_req    = 1'b0;
    o_deq_valid = 1'b0;
    o_deq_class = 2'h0;
    o_deq_len   = 16'h0000;
  end
  always @(posedge i_clock) begin
    o_tx_req <= i_go;
  end
  // Dequeue the granted class after a gap; lines scrambled once released
  always @(posedge i_clock) begin
    if (i_grant === 1'b1) begin
      cls = i_grant_class;
      repeat (i_gap) @(posedge i_clock);
      o_deq_valid <= 1'b1;
      o_deq_class <= cls;
      o_deq_len   <= i_len;
      @(posedge i_clock);
      o_deq_valid <= 1'b0;
      o_deq_class <= ~cls;
      o_deq_len   <= ~i_len;
    end
  end
endmodule // mcqs_link_model

// File: test/tb_top.sv
// Bench of the class queue scheduler: register, admission, scheduling, e2e, bind.
// Assumes the link model on the dequeue side; one 100 MHz clock.
`timescale 1ns/100ps
module tb_top;
  import mcqs_pkg::*;
  logic             clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, down = 1'b0;
  logic             fv = 1'b0, ff = 1'b0, foop = 1'b0, go = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [31:0]      wdata = 32'h0, rdata;
  logic [15:0]      rate = 16'h0001, flen = 16'h0000, dlen = 16'h0006;
  logic [2:0]       ffc = 3'h0;
  logic [1:0]       gap = 2'h0, ecls = 2'h0, eq_cls, tx_cls, dq_cls;
  logic [7:0][23:0] pir, cir;
  logic             eq_v, eq_d, tx_req, tx_g, dq_v, e_hi;
  logic [15:0]      dq_len;
  logic [3:0][9:0]  tmo;
  logic [26:0]      hp, lp;
  int               mismatches = 0, num_checks = 0;
  logic [7:0]  ra [0:14] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                             8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h60};
  logic [31:0] re [0:14] = '{32'h1, 32'h5A, 32'h59, 32'h0A, 32'h16AB, 32'h1, 32'h0A,
                             32'h32, 32'h96, 32'h2EE, 32'h0A, 32'h0A, 32'h64, 32'h64, 32'h0};
  always #5 clk = ~clk;
  mcqs_top dut (.i_clock(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_bundle_down(down), .i_rate_bpms(rate), .i_frag_valid(fv),
    .i_frag_first(ff), .i_frag_fc(ffc), .i_frag_oop(foop), .i_frag_len(flen),
    .o_enq_valid(eq_v), .o_enq_drop(eq_d), .o_enq_class(eq_cls), .i_tx_req(tx_req),
    .i_deq_valid(dq_v), .i_deq_class(dq_cls), .i_deq_len(dq_len), .o_tx_grant(tx_g),
    .o_tx_class(tx_cls), .o_reasm_tmo(tmo), .i_e2e_class(ecls), .i_fc_pir(pir),
    .i_fc_cir(cir), .o_e2e_hi(e_hi), .o_hp_pir(hp), .o_lp_weight(lp));
  mcqs_link_model link (.i_clock(clk), .i_go(go), .i_gap(gap), .i_len(dlen), .i_grant(tx_g),
    .i_grant_class(tx_cls), .o_tx_req(tx_req), .o_deq_valid(dq_v), .o_deq_class(dq_cls),
    .o_deq_len(dq_len));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task rw(input logic [7:0] a, input logic [31:0] w, input logic [31:0] exp);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= w;
    @(posedge clk);
    wr <= 1'b0;
    rdc(a, exp);
  endtask
  task frag(input logic [2:0] fc, input logic first, input logic oop, input logic [15:0] len,
            input logic expd, input logic [1:0] expc);
    @(posedge clk);
    fv   <= 1'b1;
    ff   <= first;
    ffc  <= fc;
    foop <= oop;
    flen <= len;
    @(posedge clk);
    fv <= 1'b0;
    @(negedge clk);
    chk(eq_v, 1'b1);
    chk(eq_d, expd);
    chk(eq_cls, expc);
  endtask
  task sched(input logic [1:0] g, input logic expg, input logic [1:0] expc);
    logic seen;
    logic [1:0] c;
    seen = 1'b0;
    c = 2'h0;
    @(posedge clk);
    go  <= 1'b1;
    gap <= g;
    @(posedge clk);
    go <= 1'b0;
    repeat (10) begin
      @(negedge clk);
      if (tx_g === 1'b1) begin
        seen = 1'b1;
        c = tx_cls;
      end
    end
    chk(seen, expg);
    chk(c, expc);
  endtask
  task print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #50us;
    mismatches++;
    print_verdict;
  end
  initial begin
    for (int f = 0; f < 8; f++) begin
      pir[f] = 24'(f + 1);
      cir[f] = 24'(2 * f + 2);
    end
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(tmo, {10'h064, 10'h064, 10'h00A, 10'h00A});
    chk({eq_v, tx_g}, 2'b00);
    for (int i = 0; i < 15; i++) rdc(ra[i], re[i]);
    rw(8'h20, 32'h0, 32'h0A);
    rw(8'h20, 32'h3E9, 32'h0A);
    rw(8'h20, 32'h3E8, 32'h3E8);
    rw(8'h20, 32'h0A, 32'h0A);
    rw(8'h0C, 32'h65, 32'h5A);
    rw(8'h14, 32'h64, 32'h64);
    rw(8'h14, 32'h0A, 32'h0A);
    rw(8'h30, 32'h0, 32'h0A);
    rw(8'h30, 32'h3E8, 32'h3E8);
    chk(tmo[0], 10'h3E8);
    rw(8'h04, 32'h7F, 32'h7F);
    rw(8'h08, 32'hFFFF, 32'hFFFF);
    rdc(8'h28, 32'h96);
    rw(8'h04, 32'h0, 32'h0);
    // Class 0 at one byte per ms: max 10 bytes, out-of-profile 5 bytes
    frag(3'h7, 1'b1, 1'b0, 16'h5, 1'b0, 2'h0);
    frag(3'h7, 1'b1, 1'b1, 16'h1, 1'b1, 2'h0);
    frag(3'h0, 1'b0, 1'b0, 16'h1, 1'b1, 2'h0);
    frag(3'h7, 1'b1, 1'b0, 16'h5, 1'b0, 2'h0);
    frag(3'h7, 1'b1, 1'b0, 16'h1, 1'b1, 2'h0);
    @(posedge clk);
    rate <= 16'h0002;
    frag(3'h7, 1'b1, 1'b1, 16'h1, 1'b1, 2'h0);
    frag(3'h7, 1'b1, 1'b0, 16'h2, 1'b0, 2'h0);
    rdc(8'h50, 32'h0C);
    frag(3'h5, 1'b1, 1'b0, 16'h4, 1'b0, 2'h1);
    frag(3'h2, 1'b1, 1'b0, 16'h4, 1'b0, 2'h2);
    sched(2'h0, 1'b1, 2'h0);
    sched(2'h3, 1'b1, 2'h0);
    sched(2'h0, 1'b1, 2'h1);
    sched(2'h2, 1'b1, 2'h2);
    sched(2'h0, 1'b0, 2'h0);
    chk(e_hi, 1'b0);
    rw(8'h00, 32'h1, 32'h1);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      ecls <= 2'(c);
      repeat (2) @(negedge clk);
      chk(e_hi, c < 2);
      chk({hp, lp}, {27'd36, 27'd72});
    end
    rw(8'h40, 32'h0101, 32'h0101);
    rdc(8'h44, 32'h0);
    @(posedge clk);
    down <= 1'b1;
    repeat (8) @(posedge clk);
    down <= 1'b0;
    rdc(8'h44, 32'h0101);
    chk(tmo[0], 10'h00A);
    print_verdict;
  end
endmodule // tb_top
